/* logic/drs_refresh_sched.sv */
`timescale 1ns/100ps
// Refresh scheduler: drives refresh commands onto the DRAM command pins
module drs_refresh_sched #(
  parameter int unsigned TREFI_CYC = drs_pkg::TRefiCyc,
  parameter int unsigned TRFC_CYC  = drs_pkg::TRfcCyc,
  parameter int unsigned TRP_CYC   = drs_pkg::TRpCyc
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [1:0] modeSel,
  input  wire logic       banksIdle,
  input  wire logic       pullInReq,
  input  wire logic       busGrant,
  output logic            busReq,
  output logic            refBusy,
  output logic            csN,
  output logic            actN,
  output logic            rasN,
  output logic            casN,
  output logic            weN,
  output logic [6:0]      credit
);

  // ----------------------------------------
  // Synchronisers and tick
  // ----------------------------------------
  logic idleS1_q;
  logic idleS2_q;
  logic pullS1_q;
  logic pullS2_q;
  logic grantS1_q;
  logic grantS2_q;
  logic tick;

  // Two-stage input synchronisers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idleS1_q  <= 1'b0;
      idleS2_q  <= 1'b0;
      pullS1_q  <= 1'b0;
      pullS2_q  <= 1'b0;
      grantS1_q <= 1'b0;
      grantS2_q <= 1'b0;
    end else begin
      idleS1_q  <= banksIdle;
      idleS2_q  <= idleS1_q;
      pullS1_q  <= pullInReq;
      pullS2_q  <= pullS1_q;
      grantS1_q <= busGrant;
      grantS2_q <= grantS1_q;
    end
  end

  drs_divider #(
    .PERIOD (TREFI_CYC)
  ) uDiv (
    .clk     (clk),
    .nrst    (nrst),
    .modeSel (modeSel),
    .tick    (tick)
  );

  // ----------------------------------------
  // Credit and sequencing
  // ----------------------------------------
  drs_pkg::drs_state_t st_q;
  drs_pkg::drs_state_t st_d;
  logic signed [6:0]   cred_q;
  logic signed [6:0]   cred_d;
  logic [15:0]         tmr_q;
  logic [15:0]         tmr_d;
  logic [7:0]          ahead_q;
  logic [7:0]          ahead_d;
  logic [4:0]          winCnt_q;
  logic [4:0]          winCnt_d;
  logic signed [6:0]   lim;
  logic [4:0]          winLen;
  logic                busReq_d;
  logic                cmd_d;
  logic                issued;
  logic                urgent;
  logic                early;

  // Mode limits and window length
  always_comb begin
    lim    = 7'(drs_pkg::Limit1x);
    winLen = 5'h02;
    case (modeSel)
      drs_pkg::Mode2x: begin
        lim    = 7'(drs_pkg::Limit2x);
        winLen = 5'h04;
      end
      drs_pkg::Mode4x: begin
        lim    = 7'(drs_pkg::Limit4x);
        winLen = 5'h08;
      end
      default: begin
        lim    = 7'(drs_pkg::Limit1x);
        winLen = 5'h02;
      end
    endcase
  end

  // Next-state logic
  always_comb begin
    st_d     = st_q;
    tmr_d    = tmr_q;
    busReq_d = busReq;
    cmd_d    = 1'b0;
    issued   = 1'b0;
    urgent   = (cred_q > 7'sd0);
    early    = pullS2_q && (ahead_q < 8'(2 * lim)) && (cred_q > -lim);
    case (st_q)
      drs_pkg::StIdle: begin
        busReq_d = urgent || early;
        if (busReq && grantS2_q) begin
          st_d  = drs_pkg::StPre;
          tmr_d = 16'(TRP_CYC);
        end
      end
      drs_pkg::StPre: begin
        if (!idleS2_q) begin
          tmr_d = 16'(TRP_CYC);
        end else if (tmr_q > 16'h0001) begin
          tmr_d = tmr_q - 16'h0001;
        end else begin
          st_d  = drs_pkg::StRef;
          cmd_d = 1'b1;
        end
      end
      drs_pkg::StRef: begin
        issued = 1'b1;
        st_d   = drs_pkg::StRfc;
        tmr_d  = 16'(TRFC_CYC);
      end
      drs_pkg::StRfc: begin
        if (tmr_q > 16'h0001) begin
          tmr_d = tmr_q - 16'h0001;
        end else begin
          st_d     = drs_pkg::StIdle;
          busReq_d = 1'b0;
        end
      end
      default: begin
        st_d     = drs_pkg::StIdle;
        busReq_d = 1'b0;
      end
    endcase
    // credit up per tick, top clamp; bottom clamp
    cred_d = cred_q;
    if (tick && !issued && cred_q < lim) begin
      cred_d = cred_q + 7'sd1;
    end else if (issued && !tick && cred_q > -lim) begin
      cred_d = cred_q - 7'sd1;
    end
    winCnt_d = tick ? winCnt_q + 5'h01 : winCnt_q;
    ahead_d  = ahead_q;
    if (tick && winCnt_q + 5'h01 >= winLen) begin
      winCnt_d = 5'h00;
      // A refresh in the closing cycle still counts in the new window
      ahead_d  = (issued && cred_q <= 7'sd0) ? 8'h01 : 8'h00;
    end else if (issued && cred_q <= 7'sd0) begin
      ahead_d = ahead_q + 8'h01;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q     <= drs_pkg::StIdle;
      tmr_q    <= 16'h0000;
      cred_q   <= 7'sd0;
      ahead_q  <= 8'h00;
      winCnt_q <= 5'h00;
      busReq   <= 1'b0;
    end else begin
      st_q     <= st_d;
      tmr_q    <= tmr_d;
      cred_q   <= cred_d;
      ahead_q  <= ahead_d;
      winCnt_q <= winCnt_d;
      busReq   <= busReq_d;
    end
  end

  // ----------------------------------------
  // Command pins
  // ----------------------------------------
  // refresh encoding, deselect otherwise; address left to the device
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      csN     <= 1'b1;
      actN    <= 1'b1;
      rasN    <= 1'b1;
      casN    <= 1'b1;
      weN     <= 1'b1;
      refBusy <= 1'b0;
      credit  <= 7'h00;
    end else begin
      csN     <= !cmd_d;
      actN    <= 1'b1;
      rasN    <= !cmd_d;
      casN    <= !cmd_d;
      weN     <= 1'b1;
      // busy from bus grant until the tRFC count runs out
      refBusy <= (st_d != drs_pkg::StIdle);
      credit  <= cred_d;
    end
  end
endmodule // drs_refresh_sched

/* logic/drs_pkg.sv */
package drs_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned ClkPeriodPs = 5000;
  localparam int unsigned TRefiNs     = 7800;
  localparam int unsigned TRfcNs      = 260;
  localparam int unsigned TRpPs       = 13750;
  localparam int unsigned TRefiCyc    = (TRefiNs * 1000) / ClkPeriodPs;
  localparam int unsigned TRfcCyc     = (TRfcNs * 1000 + ClkPeriodPs - 1) / ClkPeriodPs;
  localparam int unsigned TRpCyc      = (TRpPs + ClkPeriodPs - 1) / ClkPeriodPs;

  // ----------------------------------------
  // Refresh modes and limits
  // ----------------------------------------
  typedef enum logic [1:0] {
    Mode1x = 2'h0,
    Mode2x = 2'h1,
    Mode4x = 2'h2
  } drs_mode_t;

  localparam int unsigned Limit1x = 8;
  localparam int unsigned Limit2x = 16;
  localparam int unsigned Limit4x = 32;
  localparam int unsigned CreditW = 7;

  typedef enum logic [3:0] {
    StIdle = 4'h1,
    StPre  = 4'h2,
    StRef  = 4'h4,
    StRfc  = 4'h8
  } drs_state_t;

endpackage

/* logic/drs_divider.sv */
`timescale 1ns/100ps
// Interval tick: one-cycle pulse every PERIOD clocks; divides the interval by the mode
module drs_divider #(
  parameter int unsigned PERIOD = drs_pkg::TRefiCyc
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [1:0] modeSel,
  output logic            tick
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] top;
  logic        tick_d;

  // Period divided by 2 or 4 in finer modes
  always_comb begin
    top = 16'(PERIOD - 1);
    if (modeSel == drs_pkg::Mode2x) begin
      top = 16'(PERIOD / 2 - 1);
    end else if (modeSel == drs_pkg::Mode4x) begin
      top = 16'(PERIOD / 4 - 1);
    end
    tick_d = (cnt_q >= top);
    cnt_d  = tick_d ? 16'h0000 : cnt_q + 16'h0001;
  end

  // Counter register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end
endmodule // drs_divider

/* test/drs_refresh_sched_monitor.sv */
`timescale 1ns/100ps
module drs_refresh_sched_monitor #(
  parameter int unsigned TREFI_CYC = 64,
  parameter int unsigned TRFC_CYC  = 52,
  parameter int unsigned TRP_CYC   = 3
) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [1:0] modeSel,
  input wire logic       banksIdle,
  input wire logic       pullInReq,
  input wire logic       busGrant,
  input wire logic       busReq,
  input wire logic       refBusy,
  input wire logic       csN,
  input wire logic       actN,
  input wire logic       rasN,
  input wire logic       casN,
  input wire logic       weN,
  input wire logic [6:0] credit
);
  // ---
  // Helper counters
  // ---
  logic [9:0]        gap_q, gap_d;
  logic [3:0]        idle_q, idle_d;
  logic signed [7:0] lim;
  // Cycles since the last refresh and length of the idle run
  always_comb begin
    gap_d  = csN ? gap_q + {9'h000, gap_q != 10'h3FF} : 10'h000;
    idle_d = banksIdle ? idle_q + {3'h0, idle_q != 4'hF} : 4'h0;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap_q  <= 10'h3FF;
      idle_q <= 4'h0;
    end else begin
      gap_q  <= gap_d;
      idle_q <= idle_d;
    end
  end
  // Credit bound of the active mode
  assign lim = 8'sh08 <<< modeSel;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_ref_pattern: assert property (!csN |-> !rasN && !casN && actN && weN)
    else $error("bad refresh pins");
  a_ref_single: assert property (!csN |=> csN)
    else $error("refresh too long");
  a_rfc_gap: assert property (!csN |-> gap_q >= TRFC_CYC)
    else $error("refresh too soon");
  a_busy_after: assert property (!csN |=> refBusy [*8])
    else $error("busy dropped early");
  a_idle_before: assert property (!csN |-> $past(idle_q, 2) >= TRP_CYC)
    else $error("banks not idle");
  a_credit_top: assert property ($signed(credit) <= lim)
    else $error("credit above limit");
  a_credit_floor: assert property ($signed(credit) >= -lim)
    else $error("credit below limit");
  a_ref_owns_bus: assert property (!csN |-> busReq && refBusy)
    else $error("refresh without bus");
  c_refresh: cover property (!csN);
  c_top: cover property ($signed(credit) == lim);
  c_floor: cover property ($signed(credit) == -lim);
endmodule // drs_refresh_sched_monitor

bind drs_refresh_sched drs_refresh_sched_monitor #(.TREFI_CYC(TREFI_CYC), .TRFC_CYC(TRFC_CYC),
  .TRP_CYC(TRP_CYC)) mon (.*);

/* test/drs_dram_model.sv */
`timescale 1ns/100ps
// ---
// Memory device seen from its command pins
// ---
module drs_dram_model #(
  parameter int unsigned TRFC_CYC = 52
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic bankOpen,
  input  wire logic csN,
  input  wire logic actN,
  input  wire logic rasN,
  input  wire logic casN,
  input  wire logic weN,
  output logic      banksIdle,
  output int        refCnt,
  output int        badCnt
);
  int   busy_q;
  logic isRef;
  assign isRef = !csN && !rasN && !casN && actN && weN;
  // banks idle when none is open and the tRFC busy count has run out
  assign banksIdle = !bankOpen && busy_q == 0;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 0;
      refCnt <= 0;
      badCnt <= 0;
    end else if (!csN) begin
      busy_q <= TRFC_CYC;
      refCnt <= refCnt + int'(isRef);
      badCnt <= badCnt + int'(!isRef || !banksIdle);
    end else if (busy_q != 0) begin
      busy_q <= busy_q - 1;
    end
  end
endmodule // drs_dram_model

/* test/drs_refresh_sched_tb.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module drs_refresh_sched_tb;
  // ---
  // Bench
  // ---
  localparam int P = 256;
  logic       clk, nrst, bankOpen, pullInReq, busGrant, busReq, refBusy;
  logic       csN, actN, rasN, casN, weN, banksIdle;
  logic [1:0] modeSel;
  logic [6:0] credit;
  int         n_mismatch, n_compared, refCnt, badCnt, base;
  drs_refresh_sched #(.TREFI_CYC(P)) uut (.*);
  drs_dram_model dev (.*);
  // Clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_reset();
    `CHK({csN, actN, rasN, casN, weN, busReq, refBusy}, 7'h7C)
    `CHK(credit, 7'h00)
    $display("reset test done");
  endtask
  task automatic t_postpone(input int m);
    int lim;
    lim = 8 << m;
    busGrant = 1'h0;
    modeSel = 2'(m);
    cyc((lim + 3) * (P >> m));
    `CHK(credit, 7'(lim))
    `CHK(busReq, 1'h1)
    base = refCnt;
    busGrant = 1'h1;
    for (int i = 0; i < 25000 && $signed(credit) > 0; i++) cyc(1);
    `CHK(refCnt - base >= lim, 1'h1)
    `CHK(credit, 7'h00)
    $display("postpone mode %0d done", m);
  endtask
  task automatic t_blocked();
    modeSel = 2'h0;
    busGrant = 1'h0;
    cyc(80);
    bankOpen = 1'h1;
    busGrant = 1'h1;
    base = refCnt;
    cyc(3 * P);
    `CHK(refCnt, base)
    bankOpen = 1'h0;
    cyc(200);
    `CHK(refCnt > base, 1'h1)
    $display("open bank test done");
  endtask
  task automatic t_pullin(input int m);
    modeSel = 2'(m);
    pullInReq = 1'h1;
    cyc(5000);
    for (int i = 0; i < 600 && credit !== 7'(-(8 << m)); i++) cyc(1);
    `CHK(credit, 7'(-(8 << m)))
    pullInReq = 1'h0;
    $display("pull-in mode %0d done", m);
  endtask
  // Main sequence
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    nrst = 1'h0;
    bankOpen = 1'h0;
    pullInReq = 1'h0;
    busGrant = 1'h0;
    modeSel = 2'h0;
    repeat (12) @(posedge clk);
    #1 nrst = 1'h1;
    cyc(2);
    t_reset();
    for (int m = 0; m < 3; m++) t_postpone(m);
    t_blocked();
    t_pullin(0);
    t_pullin(1);
    `CHK(badCnt, 0)
    finish_test();
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
endmodule // drs_refresh_sched_tb
